// file: design/irx_params.svh
// Offsets, field positions, reset values and timing counts of the expander
`ifndef IRX_PARAMS_SVH
`define IRX_PARAMS_SVH

// Register byte offsets on the APB slave
`define IRX_OFF_VECTOR  8'h00
`define IRX_OFF_PENDING 8'h04
`define IRX_OFF_ENABLE  8'h08
`define IRX_OFF_STATUS  8'h0C
`define IRX_OFF_MASK    8'h10

// Request bit positions in the pending and enable layouts
`define IRX_BIT_RX 4
`define IRX_BIT_TX 5
`define IRX_BIT_CV 6
`define IRX_BIT_XA 7
`define IRX_BIT_XB 8
// Outstanding-level flags in the pending layout
`define IRX_BIT_OUT5 12
`define IRX_BIT_OUT6 13

// Fixed source vectors and the phantom vector
`define IRX_VEC_RX      16'h0006
`define IRX_VEC_TX      16'h0007
`define IRX_VEC_CV      16'h0004
`define IRX_VEC_XA      16'h0001
`define IRX_VEC_XB      16'h0011
`define IRX_VEC_PHANTOM 16'h0000

// Program address values that mark an acknowledge of each shared level
`define IRX_PAB_LVL5 16'h000A
`define IRX_PAB_LVL6 16'h000C

// Status bits: vector served, phantom loaded
`define IRX_STAT_SERVED  0
`define IRX_STAT_PHANTOM 1

// Reset values
`define IRX_RST_ENABLE 5'h1F
`define IRX_RST_MASK   2'h0

// Length of the active-low request pulse, in clock cycles
`define IRX_PULSE_CYC 2

`endif

// file: design/irx_pkg.sv
// Types shared by the interrupt expander
package irx_pkg;

    // Per-level request sequencer states
    typedef enum logic [1:0] {
        LV_IDLE,
        LV_PULSE,
        LV_WAIT
    } irx_lvl_e;

    // One shared CPU level: state, pulse count, request pin
    typedef struct packed {
        irx_lvl_e   st;
        logic [1:0] cnt;
        logic       reqN;
    } irx_lvl_s;

    // Whole state of the expander
    typedef struct packed {
        irx_lvl_s    lv5;
        irx_lvl_s    lv6;
        logic [15:0] vector;
        logic [8:4]  enable;
        logic [1:0]  stat;
        logic [1:0]  mask;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } irx_state_s;

endpackage

// file: design/irx_expander.sv
// Peripheral interrupt expander with APB registers and vector holding register
//
// Behaviour
// RQ1 - Ack decodes program address, clears that level
// RQ2 - Each ack loads served vector into holder
// RQ3 - Source vectors are fixed constants
// RQ4 - Serial rx, tx on bits 4,5, level five
// RQ5 - Converter, pins on bits 6-8, level six
// RQ6 - Ack without request loads phantom vector
// RQ7 - Cleared source flag yields phantom, not vector
// RQ8 - Software ack of shared level yields phantom
// RQ9 - No nonmaskable source uses shared levels
// RQ10 - CPU reads holder before unmasking interrupts
// RQ11 - CPU vector table starts at zero
// RQ12 - Handler saves context, reads holder, branches
// RQ13 - Every source has its own vector
// RQ14 - CPU disables levels one-six on branch
// RQ15 - Pulse only without outstanding request, two cycles
// RQ16 - Peripheral asserts request while flag, enable set
// RQ17 - Lowest priority number wins, others stay pending
// RQ18 - Holder keeps value between acknowledges

`include "irx_params.svh"

module irx_expander #(
    parameter int PULSE_CYC = `IRX_PULSE_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Peripheral request levels, same clock domain
    input  wire logic        serialRxIrq,
    input  wire logic        serialTxIrq,
    input  wire logic        converterIrq,
    input  wire logic        extPinIrqA,
    input  wire logic        extPinIrqB,
    // CPU side
    input  wire logic        cpuAck,
    input  wire logic [15:0] programAddrBus,
    output logic             cpuLevelFiveN,
    output logic             cpuLevelSixN,
    output logic      [15:0] vectorHoldingReg,
    output logic             irqOut
);

    // Counter is two bits wide; a pulse of zero cycles is meaningless
    if (PULSE_CYC < 1 || PULSE_CYC > 4)
    begin
        $error("irx_expander: PULSE_CYC must be 1 to 4");
    end

    localparam logic [1:0] PULSE_LAST = 2'(PULSE_CYC - 1);

    localparam irx_pkg::irx_lvl_s LVL_RST = '{
        st:   irx_pkg::LV_IDLE,
        cnt:  2'h0,
        reqN: 1'b1
    };

    localparam irx_pkg::irx_state_s ST_RST = '{
        lv5:     LVL_RST,
        lv6:     LVL_RST,
        vector:  `IRX_VEC_PHANTOM,
        enable:  `IRX_RST_ENABLE,
        stat:    2'h0,
        mask:    `IRX_RST_MASK,
        irq:     1'b0,
        pready:  1'b0,
        pslverr: 1'b0,
        prdata:  32'h0000_0000
    };

    irx_pkg::irx_state_s stQ;
    irx_pkg::irx_state_s stD;

    logic [8:4] reqRaw;
    logic [8:4] reqEff;
    logic       lvl5Req;
    logic       lvl6Req;
    logic       ack5;
    logic       ack6;
    logic [15:0] servedVec;
    logic       apbAccess;
    logic       apbWrite;
    logic       addrOk;

    // Request sequencer for one shared level
    function automatic irx_pkg::irx_lvl_s stepLevel(
        input irx_pkg::irx_lvl_s cur,
        input logic              req,
        input logic              ack
    );
        irx_pkg::irx_lvl_s nxt;
        nxt = cur;
        if (ack)
        begin
            // Acknowledge ends the outstanding request of this level
            nxt.st  = irx_pkg::LV_IDLE; // [RQ1]
            nxt.cnt = 2'h0;
        end
        else
        begin
            case (cur.st)
                irx_pkg::LV_IDLE:
                begin
                    // New pulse only when nothing is outstanding
                    if (req)
                    begin
                        nxt.st  = irx_pkg::LV_PULSE; // [RQ15]
                        nxt.cnt = PULSE_LAST;
                    end
                end
                irx_pkg::LV_PULSE:
                begin
                    if (cur.cnt == 2'h0)
                    begin
                        nxt.st = irx_pkg::LV_WAIT;
                    end
                    else
                    begin
                        nxt.cnt = cur.cnt - 2'h1;
                    end
                end
                irx_pkg::LV_WAIT:
                begin
                    nxt.st = irx_pkg::LV_WAIT;
                end
                default:
                begin
                    nxt.st  = irx_pkg::LV_IDLE;
                    nxt.cnt = 2'h0;
                end
            endcase
        end
        // Active-low request pin follows the pulse state
        nxt.reqN = (nxt.st != irx_pkg::LV_PULSE); // [RQ15]
        return nxt;
    endfunction

    // Vector of the highest-priority live request of a level
    function automatic logic [15:0] pickVector(
        input logic [8:4] req,
        input logic       isLvl6
    );
        logic [15:0] v;
        v = `IRX_VEC_PHANTOM; // [RQ6] [RQ7] [RQ8]
        if (!isLvl6)
        begin
            // Receive outranks transmit
            if (req[`IRX_BIT_RX])
            begin
                v = `IRX_VEC_RX; // [RQ17]
            end
            else if (req[`IRX_BIT_TX])
            begin
                v = `IRX_VEC_TX;
            end
        end
        else
        begin
            // Converter, then pin a, then pin b
            if (req[`IRX_BIT_CV])
            begin
                v = `IRX_VEC_CV; // [RQ17]
            end
            else if (req[`IRX_BIT_XA])
            begin
                v = `IRX_VEC_XA;
            end
            else if (req[`IRX_BIT_XB])
            begin
                v = `IRX_VEC_XB;
            end
        end
        return v;
    endfunction

    // Register read decode
    function automatic logic [31:0] readReg(
        input logic [7:0]          addr,
        input irx_pkg::irx_state_s s,
        input logic [8:4]          req
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        case (addr)
            `IRX_OFF_VECTOR:
            begin
                d[15:0] = s.vector;
            end
            `IRX_OFF_PENDING:
            begin
                d[8:4] = req;
                d[`IRX_BIT_OUT5] = (s.lv5.st != irx_pkg::LV_IDLE);
                d[`IRX_BIT_OUT6] = (s.lv6.st != irx_pkg::LV_IDLE);
            end
            `IRX_OFF_ENABLE:
            begin
                d[8:4] = s.enable;
            end
            `IRX_OFF_STATUS:
            begin
                d[1:0] = s.stat;
            end
            `IRX_OFF_MASK:
            begin
                d[1:0] = s.mask;
            end
            default:
            begin
                d = 32'h0000_0000;
            end
        endcase
        return d;
    endfunction

    // Sources on their request bits; each has its own vector
    assign reqRaw[`IRX_BIT_RX] = serialRxIrq; // [RQ4] [RQ13]
    assign reqRaw[`IRX_BIT_TX] = serialTxIrq; // [RQ4]
    assign reqRaw[`IRX_BIT_CV] = converterIrq; // [RQ5]
    assign reqRaw[`IRX_BIT_XA] = extPinIrqA; // [RQ5]
    assign reqRaw[`IRX_BIT_XB] = extPinIrqB; // [RQ5]

    // Live levels; a flag cleared before the ack drops out here
    assign reqEff  = reqRaw & stQ.enable; // [RQ7]
    assign lvl5Req = |reqEff[`IRX_BIT_TX:`IRX_BIT_RX]; // [RQ4]
    assign lvl6Req = |reqEff[`IRX_BIT_XB:`IRX_BIT_CV]; // [RQ5]

    // Only the two shared maskable levels decode; nonmaskable never
    assign ack5 = cpuAck && (programAddrBus == `IRX_PAB_LVL5); // [RQ1] [RQ9]
    assign ack6 = cpuAck && (programAddrBus == `IRX_PAB_LVL6); // [RQ1] [RQ9]

    assign servedVec = pickVector(reqEff, ack6);

    // APB access phase; slave answers one cycle into it
    assign apbAccess = psel && penable && !stQ.pready;
    // Writes land at the edge where the master samples pready high
    assign apbWrite  = psel && penable && stQ.pready && pwrite;
    assign addrOk    = (paddr == `IRX_OFF_VECTOR) || (paddr == `IRX_OFF_PENDING)
                    || (paddr == `IRX_OFF_ENABLE) || (paddr == `IRX_OFF_STATUS)
                    || (paddr == `IRX_OFF_MASK);

    // Next state of the whole block
    always_comb
    begin
        stD = stQ;

        stD.lv5 = stepLevel(stQ.lv5, lvl5Req, ack5);
        stD.lv6 = stepLevel(stQ.lv6, lvl6Req, ack6);

        // Holder changes only on a decoded ack, else keeps its value
        if (ack5 || ack6)
        begin
            stD.vector = servedVec; // [RQ2] [RQ3] [RQ18]
        end

        // Bus side
        stD.pready  = apbAccess;
        stD.pslverr = apbAccess && !addrOk;
        stD.prdata  = 32'h0000_0000;
        if (apbAccess && !pwrite)
        begin
            stD.prdata = readReg(paddr, stQ, reqEff);
        end
        if (apbWrite && paddr == `IRX_OFF_ENABLE)
        begin
            stD.enable = pwdata[8:4];
        end
        if (apbWrite && paddr == `IRX_OFF_MASK)
        begin
            stD.mask = pwdata[1:0];
        end
        // Write one to clear; set applied after so a same-cycle event wins
        if (apbWrite && paddr == `IRX_OFF_STATUS)
        begin
            stD.stat = stQ.stat & ~pwdata[1:0];
        end
        if (ack5 || ack6)
        begin
            stD.stat[`IRX_STAT_SERVED] = 1'b1;
            if (servedVec == `IRX_VEC_PHANTOM)
            begin
                stD.stat[`IRX_STAT_PHANTOM] = 1'b1; // [RQ6]
            end
        end

        stD.irq = |(stD.stat & stD.mask);
    end

    // State register
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stQ <= ST_RST;
        end
        else
        begin
            stQ <= stD;
        end
    end

    // Outputs straight from the state flops
    assign prdata           = stQ.prdata;
    assign pready           = stQ.pready;
    assign pslverr          = stQ.pslverr;
    assign cpuLevelFiveN    = stQ.lv5.reqN; // [RQ15]
    assign cpuLevelSixN     = stQ.lv6.reqN;
    assign vectorHoldingReg = stQ.vector;
    assign irqOut           = stQ.irq;

endmodule

// file: bench/irx_expander_chk.sv
// Concurrent checks on the expander's CPU-side ports
module irx_expander_chk #(
    parameter int PULSE_CYC = 2
) (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        cpuAck,
    input wire logic [15:0] programAddrBus,
    input wire logic        serialRxIrq,
    input wire logic        serialTxIrq,
    input wire logic        converterIrq,
    input wire logic        extPinIrqA,
    input wire logic        extPinIrqB,
    input wire logic        cpuLevelFiveN,
    input wire logic        cpuLevelSixN,
    input wire logic [15:0] vectorHoldingReg
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic ack5;
    logic ack6;
    logic outQ;
    logic prevFiveN;
    assign ack5 = cpuAck && programAddrBus == 16'h000A;
    assign ack6 = cpuAck && programAddrBus == 16'h000C;
    // Level five outstanding; an ack beats a pulse seen in the same cycle
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            outQ <= 1'b0;
            prevFiveN <= 1'b1;
        end
        else
        begin
            prevFiveN <= cpuLevelFiveN;
            outQ <= ack5 ? 1'b0 : ((prevFiveN && !cpuLevelFiveN) ? 1'b1 : outQ);
        end
    end
    // Two low cycles, then high again
    sequence s_two_low(p);
        !p ##1 !p ##1 p;
    endsequence
    a_pulse_five: assert property ($fell(cpuLevelFiveN) ##0 !cpuAck |-> s_two_low(cpuLevelFiveN))
        else $error("level five pulse length wrong");
    a_pulse_six: assert property ($fell(cpuLevelSixN) ##0 !cpuAck |-> s_two_low(cpuLevelSixN))
        else $error("level six pulse length wrong");
    a_one_pulse: assert property ($fell(cpuLevelFiveN) |-> !outQ)
        else $error("second pulse while outstanding");
    a_pulse_cause: assert property ($fell(cpuLevelFiveN) |-> $past(serialRxIrq) || $past(serialTxIrq))
        else $error("level five pulse without request");
    a_vec_five: assert property (ack5 && (serialRxIrq || serialTxIrq) |=>
        vectorHoldingReg == ($past(serialRxIrq) ? 16'h0006 : 16'h0007))
        else $error("level five vector wrong");
    a_phantom_five: assert property (ack5 && !serialRxIrq && !serialTxIrq |=> !(|vectorHoldingReg))
        else $error("phantom vector missing");
    a_vec_six: assert property (ack6 |=> vectorHoldingReg == ($past(converterIrq) ? 16'h0004 :
        $past(extPinIrqA) ? 16'h0001 : $past(extPinIrqB) ? 16'h0011 : 16'h0000))
        else $error("level six vector wrong");
    a_vec_hold: assert property (!(ack5 || ack6) |=> $stable(vectorHoldingReg))
        else $error("vector changed without ack");
endmodule

// file: bench/irx_cpu_model.sv
// Behavioural CPU core: takes level pulses, acknowledges, reads the holder
module irx_cpu_model (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        cpuLevelFiveN,
    input  wire logic        cpuLevelSixN,
    input  wire logic [15:0] vectorHoldingReg,
    input  wire logic [3:0]  ackDelay,
    input  wire logic        swAck5,
    output logic             cpuAck,
    output logic      [15:0] programAddrBus,
    output logic      [15:0] seenVec,
    output logic      [7:0]  vecCount
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  phase;
    logic        prevFiveN;
    logic        prevSixN;
    logic [3:0]  waitCnt;
    logic [14:0] tick;
    logic        pend5;
    logic        pend6;
    // Ack one level at a time; holder read two edges after the ack
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            {phase, waitCnt, tick, pend5, pend6, cpuAck, seenVec, vecCount} <= '0;
            programAddrBus <= 16'hFFFF;
            {prevFiveN, prevSixN} <= 2'b11;
        end
        else
        begin
            // Edge detect by hand; level pins idle high after reset
            prevFiveN <= cpuLevelFiveN;
            prevSixN <= cpuLevelSixN;
            tick <= tick + 15'h1;
            cpuAck <= 1'b0;
            programAddrBus <= {1'b1, tick}; // Fetch noise never decodes as an ack
            waitCnt <= 4'h0;
            if (phase == 2'h2)
            begin
                seenVec <= vectorHoldingReg;
                vecCount <= vecCount + 8'h1;
                phase <= 2'h0; // Mask lifted only after the read
            end
            else if (phase == 2'h1)
                phase <= 2'h2;
            else if (pend5 || pend6 || swAck5)
            begin
                waitCnt <= waitCnt + 4'h1;
                if (waitCnt == ackDelay)
                begin
                    cpuAck <= 1'b1;
                    programAddrBus <= (pend5 || swAck5) ? 16'h000A : 16'h000C;
                    phase <= 2'h1;
                    pend5 <= 1'b0;
                    pend6 <= pend6 & (pend5 | swAck5);
                end
            end
            if (prevFiveN && !cpuLevelFiveN)
                pend5 <= 1'b1;
            if (prevSixN && !cpuLevelSixN)
                pend6 <= 1'b1;
        end
    end
endmodule

// file: bench/irx_expander_tb_top.sv
// Top testbench for the interrupt expander with a CPU core model
module irx_expander_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [4:0]  req = 5'h00;
    logic [3:0]  ackDelay = 4'h0;
    logic        swAck5 = 1'b0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        cpuAck;
    logic        fiveN;
    logic        sixN;
    logic        irqOut;
    logic [15:0] program_addr_bus;
    logic [15:0] vhr;
    logic [15:0] seenVec;
    logic [7:0]  vecCount;
    int          badCount = 0;
    int          compares = 0;

    irx_expander #(.PULSE_CYC(2)) dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serialRxIrq(req[0]), .serialTxIrq(req[1]),
        .converterIrq(req[2]), .extPinIrqA(req[3]), .extPinIrqB(req[4]), .cpuAck(cpuAck),
        .programAddrBus(program_addr_bus), .cpuLevelFiveN(fiveN), .cpuLevelSixN(sixN),
        .vectorHoldingReg(vhr), .irqOut(irqOut));
    irx_cpu_model cpu (.sys_clk(sys_clk), .nrst(nrst), .cpuLevelFiveN(fiveN),
        .cpuLevelSixN(sixN), .vectorHoldingReg(vhr), .ackDelay(ackDelay), .swAck5(swAck5),
        .cpuAck(cpuAck), .programAddrBus(program_addr_bus), .seenVec(seenVec), .vecCount(vecCount));

    // Free-running 100 MHz clock
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic wrapUp();
        $display("compares %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer, held until pready is sampled; one idle edge after
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        if (n >= 40)
        begin
            badCount++;
            wrapUp();
        end
    endtask

    // Raise requests, wait for one vector read by the CPU, drop them, compare
    task automatic serve(input logic [4:0] r, input logic [15:0] exp);
        logic [7:0] n0;
        int         n;
        n0 = vecCount;
        req <= r;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (vecCount === n0 && n < 100);
        req <= 5'h00;
        if (n >= 100)
        begin
            badCount++;
            wrapUp();
        end
        chk("vector", {16'h0000, exp}, {16'h0000, seenVec});
        repeat (20) @(posedge sys_clk);
    endtask

    // Register reset values, refused vector write, unmapped address
    task automatic regs();
        apb(1'b1, 8'h00, 32'h0000_1234);
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk("vector reg", 32'h0000_0000, rd);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk("enable reg", 32'h0000_01F0, rd);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, {31'h0, err});
    endtask

    // Flag dropped before a slow ack, then a software ack, then irq mask and clear
    task automatic phantom();
        ackDelay <= 4'hC;
        req <= 5'h08;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk("pending", 32'h0000_2080, rd);
        serve(5'h00, 16'h0000);
        ackDelay <= 4'h0;
        swAck5 <= 1'b1;
        @(posedge sys_clk);
        swAck5 <= 1'b0;
        serve(5'h00, 16'h0000);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk("status", 32'h0000_0003, rd);
        apb(1'b1, 8'h10, 32'h0000_0002);
        chk("irq unmasked", 32'h0000_0001, {31'h0, irqOut});
        apb(1'b1, 8'h10, 32'h0000_0000);
        chk("irq masked", 32'h0000_0000, {31'h0, irqOut});
        apb(1'b1, 8'h10, 32'h0000_0003);
        apb(1'b1, 8'h0C, 32'h0000_0003);
        chk("irq cleared", 32'h0000_0000, {31'h0, irqOut});
    endtask

    // Gated source stays silent, then pulses once its enable is set
    task automatic gated();
        logic [7:0] n0;
        n0 = vecCount;
        apb(1'b1, 8'h08, 32'h0000_00F0);
        req <= 5'h10;
        repeat (6) @(posedge sys_clk);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk("pending gated", 32'h0000_0000, rd);
        chk("no ack gated", {24'h0, n0}, {24'h0, vecCount});
        apb(1'b1, 8'h08, 32'h0000_01F0);
        serve(5'h10, 16'h0011);
    endtask

    // Sources alone and in groups, with prompt and slow acks
    initial
    begin
        logic [4:0]  srcs[8];
        logic [15:0] vecs[8];
        srcs = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h03, 5'h1C, 5'h18};
        vecs = '{16'h0006, 16'h0007, 16'h0004, 16'h0001, 16'h0011, 16'h0006, 16'h0004, 16'h0001};
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        regs();
        for (int i = 0; i < 8; i++)
        begin
            ackDelay <= 4'(i * 2);
            serve(srcs[i], vecs[i]);
        end
        phantom();
        gated();
        wrapUp();
    end
endmodule

bind irx_expander irx_expander_chk #(.PULSE_CYC(PULSE_CYC)) uChk (.sys_clk(sys_clk),
    .nrst(nrst), .cpuAck(cpuAck), .programAddrBus(programAddrBus),
    .serialRxIrq(serialRxIrq), .serialTxIrq(serialTxIrq), .converterIrq(converterIrq),
    .extPinIrqA(extPinIrqA), .extPinIrqB(extPinIrqB), .cpuLevelFiveN(cpuLevelFiveN),
    .cpuLevelSixN(cpuLevelSixN), .vectorHoldingReg(vectorHoldingReg));
